// ### common/atf_pkg.sv
// Constants and carrier types for the async transmitter and flow control block
package atf_pkg;
  // Register addresses (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FLOW_CHARS = 8'h04;
  localparam logic [7:0] ADDR_MASKS = 8'h08;
  localparam logic [7:0] ADDR_IMMEDIATE = 8'h0c;
  localparam logic [7:0] ADDR_TX_DATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_EVENTS = 8'h18;
  // Config field positions
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_PAR_EN = 2;
  localparam int CFG_PAR_LSB = 3;
  localparam int CFG_TWO_STOP = 5;
  localparam int CFG_BREAK = 6;
  localparam int CFG_DISCARD = 7;
  localparam int CFG_INBAND = 8;
  localparam int CFG_FORCE_CTS = 9;
  localparam int CFG_AUTO_RTS = 10;
  localparam int CFG_RTS = 11;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Parity modes
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  // Status bit positions
  localparam int ST_FLOW = 0;
  localparam int ST_PENDING = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_BREAK_ACT = 3;
  localparam int ST_RTS = 4;
  // Event bit positions, cleared by writing ones
  localparam int EV_ALL_SENT = 0;
  localparam int EV_BREAK = 1;
  localparam int EV_BREAK_END = 2;
  localparam int EV_XON = 3;
  localparam int EV_XOFF = 4;
  localparam int EV_WIDTH = 5;
  // Shadow receive queue thresholds
  localparam logic [5:0] SHADOW_HIGH = 6'h14;
  localparam logic [5:0] SHADOW_EMPTY = 6'h00;

  typedef enum logic [3:0] {
    ATF_IDLE = 4'h1,
    ATF_START = 4'h2,
    ATF_DATA = 4'h4,
    ATF_TAIL = 4'h8
  } atf_tx_state_type;

  // One received character from the receiver front end
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity_ok;
    logic framing_ok;
  } atf_rx_char_type;

  // Character handed on towards the receive queue
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } atf_rx_out_type;
endpackage

// ### rtl/atf_tx_flow.sv
// Async transmitter with break, in-band and out-of-band flow control
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
// Contract
// - Each character: start bit, data bits, optional parity, configured stop bits.
// - After all sent, line idles continuously at one.
// - Break control forces line low next edge, releases after clear.
// - All-zero framed character is break: not stored, break event raised; code takes only an all-zero character with a framing error as break.
// - Break stays active until a one arrives, then break-end event.
// - Flow characters compared only over configured character length.
// - Separate eight-bit masks, one means ignore, reset to zero.
// - Recognise flow char only if framed, masked match, parity good.
// - Flow characters stored unless discard control set.
// - Every recognised resume or pause sets its event bit.
// - With in-band enabled, pause stops after current char; resume restarts.
// - In-band enable resets to zero.
// - Toggling in-band enable either way puts transmitter in resume state.
// - Transmit only with clear-to-send low and, if enabled, resume state.
// - Force clear-to-send ignores the pin; in-band gating still applies.
// - Flow status reads zero in resume state, one in pause state.
// - Immediate char sent at once if idle, else after current; queue untouched.
// - Immediate char with empty queue returns to idle and flags all sent.
// - Immediate char goes even when paused, but only with clear-to-send low.
// - Immediate char eight bits, length significant, framed like queue chars.
// - Pending flag from acceptance until fully sent; software waits for zero.
// - Auto request-to-send: high at twenty shadow bytes, low when empty.
// - Five to eight data bits; even, odd, mark or space parity.
module atf_tx_flow #(
  parameter int BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transmit queue source
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Received characters
  input wire atf_pkg::atf_rx_char_type rx_char,
  input wire logic rx_line,
  output atf_pkg::atf_rx_out_type rx_out,
  // Shadow receive queue level
  input wire logic [5:0] shadow_level,
  // Line pins
  input wire logic cts_n,
  output logic txd,
  output logic rts_n
);
  logic [11:0] cfg;
  logic [15:0] flow_char_values;
  logic [7:0] resume_char_mask;
  logic [7:0] pause_char_mask;
  logic [7:0] immediate_char_reg;
  logic immediate_char_pending;
  logic flow_state_flag;
  logic [atf_pkg::EV_WIDTH-1:0] events;
  logic break_active;
  logic cts_meta;
  logic cts_sync;
  atf_pkg::atf_tx_state_type state;
  logic [7:0] shift;
  logic [3:0] bit_idx;
  logic [15:0] bit_cnt;
  logic cur_immediate;
  logic [7:0] hold_data;
  logic hold_valid;
  logic wr_config;
  logic wr_events;
  logic wr_imm;
  logic [3:0] n_data;
  logic [3:0] n_tail;
  logic bit_end;
  logic may_send;
  logic may_imm;
  logic par_bit;
  logic xon_hit;
  logic xoff_hit;
  logic is_break;
  logic [atf_pkg::EV_WIDTH-1:0] ev_set;

  // Character length as a mask of significant data bits
  function automatic logic [7:0] len_mask(input logic [1:0] len_sel);
    len_mask = 8'hff >> (2'h3 - len_sel);
  endfunction

  function automatic logic flow_match(input logic [7:0] rx, input logic [7:0] ref_c,
                                      input logic [7:0] msk, input logic [1:0] len_sel);
    flow_match = (((rx ^ ref_c) & ~msk & len_mask(len_sel)) == 8'h00);
  endfunction

  function automatic logic break_ctl();
    break_ctl = cfg[atf_pkg::CFG_BREAK];
  endfunction

  assign wr_config = reg_wr && (reg_addr == atf_pkg::ADDR_CONFIG);
  assign wr_events = reg_wr && (reg_addr == atf_pkg::ADDR_EVENTS);
  assign wr_imm = reg_wr && (reg_addr == atf_pkg::ADDR_IMMEDIATE) && !immediate_char_pending;
  assign n_data = 4'h5 + {2'h0, cfg[atf_pkg::CFG_LEN_LSB +: 2]};
  assign n_tail = {3'h0, cfg[atf_pkg::CFG_PAR_EN]} + (cfg[atf_pkg::CFG_TWO_STOP] ? 4'h2 : 4'h1);
  assign bit_end = (bit_cnt == 16'(BIT_CYCLES - 1));
  // Pin only looked at between characters
  assign may_imm = !cts_sync || cfg[atf_pkg::CFG_FORCE_CTS];
  assign may_send = may_imm && !(cfg[atf_pkg::CFG_INBAND] && flow_state_flag);

  always_comb begin
    case (cfg[atf_pkg::CFG_PAR_LSB +: 2])
      atf_pkg::PAR_EVEN: par_bit = ^(shift & len_mask(cfg[1:0]));
      atf_pkg::PAR_ODD: par_bit = ~^(shift & len_mask(cfg[1:0]));
      atf_pkg::PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  end

  // Receive side recognition
  assign is_break = rx_char.valid && !rx_char.framing_ok
                    && ((rx_char.data & len_mask(cfg[1:0])) == 8'h00);
  assign xon_hit = rx_char.valid && rx_char.framing_ok && rx_char.parity_ok
                   && flow_match(rx_char.data, flow_char_values[7:0], resume_char_mask, cfg[1:0]);
  assign xoff_hit = rx_char.valid && rx_char.framing_ok && rx_char.parity_ok && !xon_hit
                    && flow_match(rx_char.data, flow_char_values[15:8], pause_char_mask, cfg[1:0]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
    end else if (clk_en) begin
      cts_meta <= cts_n;
      cts_sync <= cts_meta;
    end
  end

  // Configuration and flow registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= atf_pkg::CFG_RESET;
      flow_char_values <= 16'h0000;
      resume_char_mask <= atf_pkg::MASK_RESET;
      pause_char_mask <= atf_pkg::MASK_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == atf_pkg::ADDR_CONFIG) begin
        cfg <= reg_wdata[11:0];
      end else if (reg_addr == atf_pkg::ADDR_FLOW_CHARS) begin
        flow_char_values <= reg_wdata[15:0];
      end else if (reg_addr == atf_pkg::ADDR_MASKS) begin
        resume_char_mask <= reg_wdata[7:0];
        pause_char_mask <= reg_wdata[15:8];
      end
    end
  end

  // Flow state: pause takes effect when the next character would start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flow_state_flag <= 1'b0;
    end else if (clk_en) begin
      // Toggle acts at the write itself, so a status read right after it is current
      if (wr_config && (reg_wdata[atf_pkg::CFG_INBAND] != cfg[atf_pkg::CFG_INBAND])) begin
        flow_state_flag <= 1'b0;
      end else if (cfg[atf_pkg::CFG_INBAND] && xoff_hit) begin
        flow_state_flag <= 1'b1;
      end else if (cfg[atf_pkg::CFG_INBAND] && xon_hit) begin
        flow_state_flag <= 1'b0;
      end
    end
  end

  // Break condition tracking
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      break_active <= 1'b0;
    end else if (clk_en) begin
      if (is_break) begin
        break_active <= 1'b1;
      end else if (break_active && rx_line) begin
        break_active <= 1'b0;
      end
    end
  end

  // Received characters forwarded, break and discarded flow chars dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out <= '0;
    end else if (clk_en) begin
      rx_out.valid <= rx_char.valid && !is_break
                      && !(cfg[atf_pkg::CFG_DISCARD] && (xon_hit || xoff_hit));
      rx_out.data <= rx_char.data & len_mask(cfg[1:0]);
    end
  end

  // Immediate character register and pending flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      immediate_char_reg <= 8'h00;
      immediate_char_pending <= 1'b0;
    end else if (clk_en) begin
      if (wr_imm) begin
        immediate_char_reg <= reg_wdata[7:0];
        immediate_char_pending <= 1'b1;
      end else if (state == atf_pkg::ATF_TAIL && cur_immediate && bit_end && bit_idx == n_tail - 4'h1) begin
        immediate_char_pending <= 1'b0;
      end
    end
  end

  // One-deep holding slot; ready is a flop kept as the inverse of the slot flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_valid <= 1'b0;
      hold_data <= 8'h00;
      tx_ready <= 1'b1;
    end else if (clk_en) begin
      if (tx_valid && !hold_valid) begin
        hold_valid <= 1'b1;
        hold_data <= tx_data;
        tx_ready <= 1'b0;
      end else if (state == atf_pkg::ATF_IDLE && hold_valid && may_send
                   && !immediate_char_pending && !break_ctl()) begin
        hold_valid <= 1'b0;
        tx_ready <= 1'b1;
      end
    end
  end

  // Transmit character sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= atf_pkg::ATF_IDLE;
      shift <= 8'h00;
      bit_idx <= 4'h0;
      bit_cnt <= 16'h0000;
      cur_immediate <= 1'b0;
    end else if (clk_en) begin
      case (state)
        atf_pkg::ATF_IDLE: begin
          bit_cnt <= 16'h0000;
          bit_idx <= 4'h0;
          if (!break_ctl() && immediate_char_pending && may_imm) begin
            shift <= immediate_char_reg;
            cur_immediate <= 1'b1;
            state <= atf_pkg::ATF_START;
          end else if (!break_ctl() && hold_valid && may_send && !immediate_char_pending) begin
            shift <= hold_data;
            cur_immediate <= 1'b0;
            state <= atf_pkg::ATF_START;
          end
        end
        atf_pkg::ATF_START: begin
          bit_cnt <= bit_end ? 16'h0000 : bit_cnt + 16'h0001;
          if (bit_end) begin
            state <= atf_pkg::ATF_DATA;
          end
        end
        atf_pkg::ATF_DATA: begin
          bit_cnt <= bit_end ? 16'h0000 : bit_cnt + 16'h0001;
          if (bit_end) begin
            bit_idx <= (bit_idx == n_data - 4'h1) ? 4'h0 : bit_idx + 4'h1;
            if (bit_idx == n_data - 4'h1) begin
              state <= atf_pkg::ATF_TAIL;
            end
          end
        end
        atf_pkg::ATF_TAIL: begin
          bit_cnt <= bit_end ? 16'h0000 : bit_cnt + 16'h0001;
          if (bit_end) begin
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == n_tail - 4'h1) begin
              state <= atf_pkg::ATF_IDLE;
            end
          end
        end
        default: state <= atf_pkg::ATF_IDLE;
      endcase
    end
  end

  // Serial output from a flip-flop; break overrides everything
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txd <= 1'b1;
    end else if (clk_en) begin
      if (break_ctl()) begin
        txd <= 1'b0;
      end else begin
        case (state)
          atf_pkg::ATF_START: txd <= bit_end ? shift[0] : 1'b0;
          atf_pkg::ATF_DATA: begin
            if (bit_end && bit_idx == n_data - 4'h1) begin
              txd <= cfg[atf_pkg::CFG_PAR_EN] ? par_bit : 1'b1;
            end else begin
              txd <= bit_end ? shift[bit_idx[2:0] + 3'h1] : shift[bit_idx[2:0]];
            end
          end
          atf_pkg::ATF_TAIL: begin
            if (!bit_end && bit_idx == 4'h0 && cfg[atf_pkg::CFG_PAR_EN]) begin
              txd <= par_bit;
            end else begin
              txd <= 1'b1;
            end
          end
          atf_pkg::ATF_IDLE: txd <= (immediate_char_pending && may_imm) || (hold_valid && may_send) ? 1'b0 : 1'b1;
          default: txd <= 1'b1;
        endcase
      end
    end
  end

  // Auto request-to-send from the shadow queue level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else if (clk_en) begin
      if (!cfg[atf_pkg::CFG_AUTO_RTS]) begin
        rts_n <= !cfg[atf_pkg::CFG_RTS];
      end else if (!cfg[atf_pkg::CFG_RTS]) begin
        if (shadow_level >= atf_pkg::SHADOW_HIGH) begin
          rts_n <= 1'b1;
        end else if (shadow_level == atf_pkg::SHADOW_EMPTY) begin
          rts_n <= 1'b0;
        end
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb begin
    ev_set = '0;
    ev_set[atf_pkg::EV_ALL_SENT] = (state == atf_pkg::ATF_TAIL) && bit_end && (bit_idx == n_tail - 4'h1)
                                   && !hold_valid && !tx_valid;
    ev_set[atf_pkg::EV_BREAK] = is_break && !break_active;
    ev_set[atf_pkg::EV_BREAK_END] = break_active && rx_line && !is_break;
    ev_set[atf_pkg::EV_XON] = xon_hit;
    ev_set[atf_pkg::EV_XOFF] = xoff_hit;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      events <= '0;
    end else if (clk_en) begin
      events <= (events & ~(wr_events ? reg_wdata[atf_pkg::EV_WIDTH-1:0] : '0)) | ev_set;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == atf_pkg::ADDR_CONFIG) begin
          reg_rdata <= {20'h00000, cfg};
        end else if (reg_addr == atf_pkg::ADDR_FLOW_CHARS) begin
          reg_rdata <= {16'h0000, flow_char_values};
        end else if (reg_addr == atf_pkg::ADDR_MASKS) begin
          reg_rdata <= {16'h0000, pause_char_mask, resume_char_mask};
        end else if (reg_addr == atf_pkg::ADDR_IMMEDIATE) begin
          reg_rdata <= {24'h000000, immediate_char_reg};
        end else if (reg_addr == atf_pkg::ADDR_STATUS) begin
          reg_rdata <= {27'h0000000, !rts_n, break_active, state != atf_pkg::ATF_IDLE,
                        immediate_char_pending, flow_state_flag};
        end else if (reg_addr == atf_pkg::ADDR_EVENTS) begin
          reg_rdata <= {27'h0000000, events};
        end
      end
    end
  end
endmodule

// ### tb/atf_checker.sv
// Port-level assertions for the async transmitter and flow control block
`timescale 1ns/100ps
module atf_checker #(
  parameter int BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Receive side
  input wire atf_pkg::atf_rx_char_type rx_char,
  input wire atf_pkg::atf_rx_out_type rx_out,
  input wire logic [5:0] shadow_level,
  // Line pins
  input wire logic cts_n,
  input wire logic txd,
  input wire logic rts_n
);
  logic [11:0] cfg;
  logic mask_wr;
  logic [7:0] hi_cnt;
  logic [3:0] cts_cnt;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Shadow of the config word, tracked from the register writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= atf_pkg::CFG_RESET;
      mask_wr <= 1'b0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == atf_pkg::ADDR_CONFIG)
        cfg <= reg_wdata[11:0];
      if (reg_addr == atf_pkg::ADDR_MASKS)
        mask_wr <= 1'b1;
    end
  end

  // Saturating run lengths of a high line and of a high clear-to-send
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
      cts_cnt <= 4'h0;
    end else begin
      hi_cnt <= !txd ? 8'h00 : (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
      cts_cnt <= !cts_n ? 4'h0 : (cts_cnt == 4'hf) ? cts_cnt : cts_cnt + 4'h1;
    end
  end

  property p_break_set;
    reg_wr && clk_en && reg_addr == atf_pkg::ADDR_CONFIG && reg_wdata[atf_pkg::CFG_BREAK] |-> ##2 !txd;
  endproperty
  a_break_set: assert property (p_break_set)
    else $error("line not low after break set");

  // A start after a long idle needs clear-to-send low, allowing the synchroniser delay
  property p_cts_gate;
    $fell(txd) && hi_cnt >= 12 * BIT_CYCLES && !cfg[atf_pkg::CFG_FORCE_CTS] && !cfg[atf_pkg::CFG_BREAK]
      |-> cts_cnt < 4'h5;
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("character started with clear-to-send high");

  property p_rts_hi;
    cfg[atf_pkg::CFG_AUTO_RTS] && !cfg[atf_pkg::CFG_RTS] && shadow_level >= atf_pkg::SHADOW_HIGH |-> ##[1:2] rts_n;
  endproperty
  a_rts_hi: assert property (p_rts_hi)
    else $error("request-to-send not withdrawn at threshold");

  property p_rts_lo;
    cfg[atf_pkg::CFG_AUTO_RTS] && !cfg[atf_pkg::CFG_RTS] && shadow_level == atf_pkg::SHADOW_EMPTY |-> ##[1:2] !rts_n;
  endproperty
  a_rts_lo: assert property (p_rts_lo)
    else $error("request-to-send not asserted when empty");

  property p_fcs_off;
    reg_rd && reg_addr == atf_pkg::ADDR_STATUS && !cfg[atf_pkg::CFG_INBAND] |=> !reg_rdata[atf_pkg::ST_FLOW];
  endproperty
  a_fcs_off: assert property (p_fcs_off)
    else $error("pause state with in-band control off");

  property p_mask_rst;
    reg_rd && reg_addr == atf_pkg::ADDR_MASKS && !mask_wr |=> reg_rdata[15:0] == 16'h0000;
  endproperty
  a_mask_rst: assert property (p_mask_rst)
    else $error("masks not zero after reset");

  property p_break_drop;
    rx_char.valid && !rx_char.framing_ok && rx_char.data == 8'h00 |=> !rx_out.valid;
  endproperty
  a_break_drop: assert property (p_break_drop)
    else $error("break character stored");

  property p_flow_store;
    rx_char.valid && rx_char.framing_ok && rx_char.parity_ok && !cfg[atf_pkg::CFG_DISCARD]
      |=> rx_out.valid && rx_out.data == $past(rx_char.data);
  endproperty
  a_flow_store: assert property (p_flow_store)
    else $error("received character not stored");
endmodule

bind atf_tx_flow atf_checker #(.BIT_CYCLES(BIT_CYCLES)) u_checker (
  .mclk(mclk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rx_char(rx_char),
  .rx_out(rx_out),
  .shadow_level(shadow_level),
  .cts_n(cts_n),
  .txd(txd),
  .rts_n(rts_n)
);

// ### tb/atf_remote.sv
// Remote station model: decodes characters from the serial line
`timescale 1ns/100ps
module atf_remote #(
  parameter int BIT_CYCLES = 16
) (
  // Clock
  input wire logic mclk,
  // Line and frame format
  input wire logic txd,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic two_stop,
  // Decoded character: data, parity bit, stop bits good
  output logic [9:0] got,
  output logic got_tgl
);
  logic ok;
  logic p;
  logic [7:0] d;

  // Samples one cycle into each bit, which is mid-bit only for short bit times
  initial begin
    got = 10'h000;
    got_tgl = 1'b0;
    forever begin
      @(negedge txd);
      @(posedge mclk);
      #1;
      ok = !txd;
      d = 8'h00;
      p = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT_CYCLES) @(posedge mclk);
        #1;
        d[i] = txd;
      end
      if (par_en) begin
        repeat (BIT_CYCLES) @(posedge mclk);
        #1;
        p = txd;
      end
      for (int i = 0; i < (two_stop ? 2 : 1); i++) begin
        repeat (BIT_CYCLES) @(posedge mclk);
        #1;
        ok = ok & txd;
      end
      got = {d, p, ok};
      got_tgl = ~got_tgl;
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the async transmitter and flow control block
`timescale 1ns/100ps
module tb_top;
  localparam int BC = 2;
  logic mclk, rst_n, reg_wr, reg_rd, tx_valid, tx_ready, rx_line, cts_n, txd, rts_n;
  logic par_en, two_stop, got_tgl;
  logic [7:0] reg_addr, tx_data, d;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [5:0] shadow_level;
  logic [5:0] lv[4] = '{6'h13, 6'h14, 6'h05, 6'h00};
  logic [3:0] nbits;
  logic [1:0] pm;
  logic [9:0] got;
  logic [9:0] exp_q[$];
  atf_pkg::atf_rx_char_type rx_char;
  atf_pkg::atf_rx_out_type rx_out;
  int n_errors = 0;
  int cmp_count = 0;

  atf_tx_flow #(.BIT_CYCLES(BC)) DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_char(rx_char), .rx_line(rx_line), .rx_out(rx_out),
    .shadow_level(shadow_level), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
  atf_remote #(.BIT_CYCLES(BC)) u_remote (.mclk(mclk), .txd(txd), .nbits(nbits), .par_en(par_en),
    .two_stop(two_stop), .got(got), .got_tgl(got_tgl));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input bit chk = 1);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    if (chk)
      check(v & m, e);
  endtask

  function automatic logic [31:0] cw(input logic [31:0] extra);
    return extra | {26'h0, two_stop, pm, par_en, 2'(nbits - 4'h5)};
  endfunction

  function automatic logic pbit(input logic [7:0] x);
    return (pm == atf_pkg::PAR_MARK) ? 1'b1 : (pm == atf_pkg::PAR_SPACE) ? 1'b0 : ^x ^ (pm == atf_pkg::PAR_ODD);
  endfunction

  task automatic ex(input logic [7:0] x);
    logic [7:0] m;
    m = x & 8'((9'h001 << nbits) - 9'h001);
    exp_q.push_back({m, par_en & pbit(m), 1'b1});
  endtask

  task automatic put(input logic [7:0] x);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= x;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  // Polls status until nothing is shifting or pending
  task automatic wait_idle;
    repeat (200) begin
      rdc(atf_pkg::ADDR_STATUS, 32'h0, 32'h0, 0);
      if (v[atf_pkg::ST_BUSY] === 1'b0 && v[atf_pkg::ST_PENDING] === 1'b0)
        break;
    end
    repeat (4) @(posedge mclk);
    check(32'(exp_q.size()), 32'h0);
  endtask

  task automatic rx(input logic [7:0] x, input logic par_ok, input logic frm_ok);
    @(posedge mclk);
    rx_char <= '{1'b1, x, par_ok, frm_ok};
    @(posedge mclk);
    rx_char <= '0;
    #1;
    v = {23'h0, rx_out};
  endtask

  // Any frame arriving with nothing expected is a gating fault
  always @(got_tgl) begin
    if ($time > 0) begin
      if (exp_q.size() == 0)
        check({22'h0, got}, 32'hffffffff);
      else
        check({22'h0, got}, {22'h0, exp_q.pop_front()});
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_char = '0;
    rx_line = 1'b1;
    shadow_level = 6'h00;
    cts_n = 1'b0;
    nbits = 4'h8;
    par_en = 1'b0;
    pm = 2'h0;
    two_stop = 1'b0;
    v = $urandom(32'h8736);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(atf_pkg::ADDR_CONFIG, 32'hffffffff, 32'h0);
    rdc(atf_pkg::ADDR_MASKS, 32'hffff, 32'h0);
    rdc(atf_pkg::ADDR_TX_DATA, 32'hffffffff, 32'h0);
    rdc(atf_pkg::ADDR_STATUS, 32'h1, 32'h0);
    for (int i = 0; i < 16; i++) begin
      nbits = 4'(5 + i % 4);
      pm = 2'(i / 4);
      par_en = i[0] ^ i[2];
      two_stop = i[1];
      wr(atf_pkg::ADDR_CONFIG, cw(32'h0));
      d = 8'($urandom);
      ex(d);
      put(d);
      wait_idle();
    end
    wr(atf_pkg::ADDR_EVENTS, 32'h1f);
    d = 8'($urandom);
    ex(d);
    wr(atf_pkg::ADDR_IMMEDIATE, {24'h0, d});
    rdc(atf_pkg::ADDR_STATUS, 32'h2, 32'h2);
    wait_idle();
    rdc(atf_pkg::ADDR_EVENTS, 32'h1, 32'h1);
    // Immediate goes between a shifting character and the next queued one
    ex(8'h5a);
    ex(8'h3c);
    ex(8'ha5);
    put(8'h5a);
    put(8'ha5);
    wr(atf_pkg::ADDR_IMMEDIATE, 32'h3c);
    wait_idle();
    par_en = 1'b1;
    wr(atf_pkg::ADDR_FLOW_CHARS, 32'h1311);
    wr(atf_pkg::ADDR_EVENTS, 32'h1f);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h100));
    rdc(atf_pkg::ADDR_STATUS, 32'h1, 32'h0);
    rx(8'h13, 1'b1, 1'b1);
    check(v, 32'h113);
    rdc(atf_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rdc(atf_pkg::ADDR_EVENTS, 32'h18, 32'h10);
    put(8'h77);
    repeat (60) @(posedge mclk);
    ex(8'h66);
    wr(atf_pkg::ADDR_IMMEDIATE, 32'h66);
    repeat (40) @(posedge mclk);
    rx(8'h11, 1'b0, 1'b1);
    rdc(atf_pkg::ADDR_STATUS, 32'h1, 32'h1);
    wr(atf_pkg::ADDR_MASKS, 32'h0080);
    ex(8'h77);
    rx(8'h91, 1'b1, 1'b1);
    wait_idle();
    rdc(atf_pkg::ADDR_EVENTS, 32'h8, 32'h8);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h180));
    rx(8'h13, 1'b1, 1'b1);
    check(v & 32'h100, 32'h0);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h0));
    rdc(atf_pkg::ADDR_STATUS, 32'h1, 32'h0);
    @(posedge mclk);
    cts_n <= 1'b1;
    put(8'h2c);
    repeat (60) @(posedge mclk);
    ex(8'h2c);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h200));
    wait_idle();
    par_en = 1'b0;
    wr(atf_pkg::ADDR_CONFIG, cw(32'h0));
    cts_n <= 1'b0;
    exp_q.push_back(10'h000);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h40));
    repeat (30) @(posedge mclk);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h0));
    wait_idle();
    check({31'h0, txd}, 32'h1);
    wr(atf_pkg::ADDR_EVENTS, 32'h1f);
    rx_line <= 1'b0;
    rx(8'h00, 1'b1, 1'b0);
    check(v, 32'h0);
    rdc(atf_pkg::ADDR_STATUS, 32'h8, 32'h8);
    rdc(atf_pkg::ADDR_EVENTS, 32'h6, 32'h2);
    rx_line <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(atf_pkg::ADDR_EVENTS, 32'h6, 32'h6);
    wr(atf_pkg::ADDR_CONFIG, cw(32'h400));
    foreach (lv[k]) begin
      @(posedge mclk);
      shadow_level <= lv[k];
      repeat (3) @(posedge mclk);
      #1;
      check({31'h0, rts_n}, {31'h0, k == 1 || k == 2});
    end
    stop_test();
  end
endmodule
